// file: design/occfg_channel.v
`timescale 1ns/1ps
`default_nettype none
`include "occfg_regs.vh"
module occfg_channel #(
  parameter RATIO_W      = 12,
  parameter SLIP_W       = 12,
  parameter COARSE_TAPS  = 17,
  parameter IS_DEV_CLOCK = 1
) (
  input  wire       MCLK,            // Half-VCO-period clock
  input  wire       RST_B,           // Synchronous reset, low
  input  wire [7:0] REG_ADDR,        // Register byte address
  input  wire [7:0] REG_WDATA,       // Write data
  input  wire       REG_WE,          // Write strobe, one cycle
  input  wire       REG_RE,          // Read strobe, one cycle
  output reg  [7:0] REG_RDATA,       // Read data, next cycle
  output reg        REG_RVALID,      // Read data valid pulse
  input  wire [7:0] DIV_RATIO_LOW,   // Low divider byte, held elsewhere
  input  wire       SLIP_ENABLE,     // Channel takes slip events
  input  wire       MULTISLIP_WE,    // Load MULTISLIP_VALUE
  input  wire       MULTISLIP_VALUE, // Repeat-slip enable value
  input  wire       PULSE_GEN_MODE,  // Channel in pulse generator mode
  input  wire       PULSE_IDLE,      // Pulse generator between bursts
  input  wire       SERIAL_SLIP,     // Serial port slip pulse
  input  wire       GENERAL_PURPOSE_INPUT, // Slip pin, async
  input  wire       SYNC_EVENT,      // Phase alignment event pulse
  input  wire       PULSE_GEN_REQ,   // Pulse generator request pulse
  input  wire       ANALOG_DELAY_IN, // Return from analog delay, async
  input  wire       PAIR_CHANNEL_IN, // Paired channel output
  output reg  [4:0] FINE_SKEW_STEPS, // Effective fine steps of 25 ps
  output reg        CLK_OUT,         // Channel output clock
  output reg        SLIP_BUSY,       // Slip sequence running
  output reg        MULTISLIP_ON     // Repeat-slip enable state
);

  reg  [4:0]  fine_q;
  reg  [4:0]  coarse_q;
  reg  [7:0]  slip_low_q;
  reg  [3:0]  slip_high_q;
  reg  [1:0]  src_q;
  reg  [1:0]  idle_q;
  reg  [3:0]  div_high_q;
  reg         multi_q;
  reg  [1:0]  gpi_sync_q;
  reg         gpi_prev_q;
  reg  [1:0]  ana_sync_q;
  reg         vco_q;
  reg  [COARSE_TAPS:0] line_q;
  reg  [4:0]  coarse_eff;
  reg         sel_d;
  reg  [7:0]  rdata_d;
  wire        div_out;
  wire        div_busy;
  wire        gpi_rise;
  wire        slip_one;
  wire        slip_multi;
  wire [RATIO_W-1:0] ratio;
  wire [SLIP_W-1:0]  slip_count;

  // Twelve-bit divide ratio: high nibble above the low byte
  assign ratio = {div_high_q, DIV_RATIO_LOW};
  assign slip_count = {slip_high_q, slip_low_q};

  // Pin slip edge, looked at only after both sync stages
  assign gpi_rise = gpi_sync_q[1] & ~gpi_prev_q;

  // Explicit requests slip once; with repeat on all sources repeat
  assign slip_one   = SLIP_ENABLE & ~multi_q & (SERIAL_SLIP | gpi_rise);
  assign slip_multi = SLIP_ENABLE & multi_q &
                      (SERIAL_SLIP | gpi_rise | SYNC_EVENT | PULSE_GEN_REQ);

  occfg_divider #(
    .RATIO_W    (RATIO_W),
    .SLIP_W     (SLIP_W)
  ) u_div (
    .mclk       (MCLK),
    .rst_b      (RST_B),
    .ratio      (ratio),
    .slip_count (slip_count),
    .slip_one   (slip_one),
    .slip_multi (slip_multi),
    .div_out_q  (div_out),
    .busy_q     (div_busy)
  );

  // Register writes; reserved bits are not stored
  always @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      fine_q      <= 5'h00;
      coarse_q    <= 5'h00;
      slip_low_q  <= `OCCFG_RST_BYTE;
      slip_high_q <= 4'h0;
      src_q       <= `OCCFG_SRC_DIVIDER;
      idle_q      <= `OCCFG_IDLE_NORMAL;
      div_high_q  <= 4'h0;
    end
    else if (REG_WE)
    begin
      case (REG_ADDR)
        `OCCFG_ADDR_FINE_SKEW:   fine_q      <= REG_WDATA[`OCCFG_SKEW_MSB:0];
        `OCCFG_ADDR_COARSE_SKEW: coarse_q    <= REG_WDATA[`OCCFG_SKEW_MSB:0];
        `OCCFG_ADDR_SLIP_LOW:    slip_low_q  <= REG_WDATA;
        `OCCFG_ADDR_SLIP_HIGH:   slip_high_q <= REG_WDATA[`OCCFG_NIBBLE_MSB:0];
        `OCCFG_ADDR_SOURCE_SEL:  src_q       <= REG_WDATA[`OCCFG_SRC_MSB:0];
        `OCCFG_ADDR_IDLE_OVR:    idle_q      <= REG_WDATA[`OCCFG_IDLE_MSB:`OCCFG_IDLE_LSB];
        `OCCFG_ADDR_DIV_HIGH:    div_high_q  <= REG_WDATA[`OCCFG_NIBBLE_MSB:0];
        default:                 fine_q      <= fine_q;
      endcase
    end
  end

  // Read mux; unmapped addresses and reserved bits read zero
  always @*
  begin
    rdata_d = 8'h00;
    case (REG_ADDR)
      `OCCFG_ADDR_FINE_SKEW:   rdata_d = {3'h0, fine_q};
      `OCCFG_ADDR_COARSE_SKEW: rdata_d = {3'h0, coarse_q};
      `OCCFG_ADDR_SLIP_LOW:    rdata_d = slip_low_q;
      `OCCFG_ADDR_SLIP_HIGH:   rdata_d = {4'h0, slip_high_q};
      `OCCFG_ADDR_SOURCE_SEL:  rdata_d = {6'h00, src_q};
      `OCCFG_ADDR_IDLE_OVR:    rdata_d = {idle_q, 6'h00};
      `OCCFG_ADDR_DIV_HIGH:    rdata_d = {4'h0, div_high_q};
      default:                 rdata_d = 8'h00;
    endcase
  end

  // Coarse tap clamped; codes past the last step act as the last step
  always @*
  begin
    coarse_eff = coarse_q;
    if (coarse_q > `OCCFG_COARSE_MAX)
      coarse_eff = `OCCFG_COARSE_MAX;
  end

  // Output source mux with idle-level override
  always @*
  begin
    sel_d = 1'b0;
    case (src_q)
      `OCCFG_SRC_DIVIDER: sel_d = line_q[coarse_eff];
      `OCCFG_SRC_ANALOG:  sel_d = ana_sync_q[1];
      `OCCFG_SRC_PAIR:    sel_d = PAIR_CHANNEL_IN;
      `OCCFG_SRC_VCO:     sel_d = vco_q;
      default:            sel_d = 1'b0;
    endcase
    // Reserved override codes fall back to normal output
    if (PULSE_GEN_MODE && PULSE_IDLE && idle_q == `OCCFG_IDLE_LOGIC0)
      sel_d = 1'b0;
  end

  // Repeat-slip enable: reset default depends on channel flavour
  always @(posedge MCLK)
  begin
    if (!RST_B)
      multi_q <= (IS_DEV_CLOCK != 0);
    else if (MULTISLIP_WE)
      multi_q <= MULTISLIP_VALUE;
  end

  // Synchronisers, delay line, fundamental and output flops
  always @(posedge MCLK)
  begin
    if (!RST_B)
    begin
      gpi_sync_q      <= 2'h0;
      gpi_prev_q      <= 1'b0;
      ana_sync_q      <= 2'h0;
      vco_q           <= 1'b0;
      line_q          <= {(COARSE_TAPS+1){1'b0}};
      FINE_SKEW_STEPS <= 5'h00;
      CLK_OUT         <= 1'b0;
      SLIP_BUSY       <= 1'b0;
      MULTISLIP_ON    <= 1'b0;
      REG_RDATA       <= 8'h00;
      REG_RVALID      <= 1'b0;
    end
    else
    begin
      gpi_sync_q <= {gpi_sync_q[0], GENERAL_PURPOSE_INPUT};
      gpi_prev_q <= gpi_sync_q[1];
      ana_sync_q <= {ana_sync_q[0], ANALOG_DELAY_IN};
      // Toggling each half period models the undivided VCO clock
      vco_q      <= ~vco_q;
      // One tap per half VCO period; no extra noise, costs flops
      line_q     <= {line_q[COARSE_TAPS-1:0], div_out};
      // Excess fine codes hold at the last of 24 steps
      FINE_SKEW_STEPS <= (fine_q > `OCCFG_FINE_MAX) ? `OCCFG_FINE_MAX : fine_q;
      CLK_OUT      <= sel_d;
      SLIP_BUSY    <= div_busy;
      MULTISLIP_ON <= multi_q;
      REG_RDATA    <= REG_RE ? rdata_d : 8'h00;
      REG_RVALID   <= REG_RE;
    end
  end

endmodule
`default_nettype wire

// file: design/occfg_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "occfg_regs.vh"
module occfg_divider #(
  parameter RATIO_W = 12,
  parameter SLIP_W  = 12
) (
  input  wire               mclk,       // Half-VCO-period clock
  input  wire               rst_b,      // Synchronous reset, low
  input  wire [RATIO_W-1:0] ratio,      // Divide ratio
  input  wire [SLIP_W-1:0]  slip_count, // Repeat count
  input  wire               slip_one,   // Single slip request
  input  wire               slip_multi, // Repeated slip request
  output reg                div_out_q,  // Divided clock
  output reg                busy_q      // Slip in progress
);

  reg [RATIO_W-1:0] cnt_q;
  reg [RATIO_W-1:0] cnt_d;
  reg [SLIP_W:0]    hold_q;
  reg [SLIP_W:0]    hold_d;
  wire [RATIO_W-1:0] ratio_eff;

  // Ratio 0 is unsupported; treat like 1 so the output keeps running
  assign ratio_eff = (ratio == {RATIO_W{1'b0}}) ? {{(RATIO_W-1){1'b0}}, 1'b1} : ratio;

  // Slip hold: each VCO period of slip freezes the divider two half periods
  always @*
  begin
    hold_d = hold_q;
    if (hold_q != {(SLIP_W+1){1'b0}})
      hold_d = hold_q - {{SLIP_W{1'b0}}, 1'b1};
    else if (slip_multi)
      hold_d = {slip_count, 1'b0};
    else if (slip_one)
      hold_d = {{(SLIP_W-1){1'b0}}, `OCCFG_HALF_PER_VCO};
  end

  // Toggle every ratio half periods gives exact 50 percent duty, odd or even
  always @*
  begin
    cnt_d = cnt_q;
    if (hold_q == {(SLIP_W+1){1'b0}})
    begin
      if (cnt_q >= ratio_eff - {{(RATIO_W-1){1'b0}}, 1'b1})
        cnt_d = {RATIO_W{1'b0}};
      else
        cnt_d = cnt_q + {{(RATIO_W-1){1'b0}}, 1'b1};
    end
  end

  // State registers
  always @(posedge mclk)
  begin
    if (!rst_b)
    begin
      cnt_q     <= {RATIO_W{1'b0}};
      hold_q    <= {(SLIP_W+1){1'b0}};
      div_out_q <= 1'b0;
      busy_q    <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      hold_q <= hold_d;
      busy_q <= (hold_d != {(SLIP_W+1){1'b0}});
      if (hold_q == {(SLIP_W+1){1'b0}} &&
          cnt_q >= ratio_eff - {{(RATIO_W-1){1'b0}}, 1'b1})
        div_out_q <= ~div_out_q;
    end
  end

endmodule
`default_nettype wire

// file: design/occfg_regs.vh
// Operation
// - Divide ratio bits 11:8 come from bits 3:0 of the divide-high register.
// - Five-bit fine skew code gives up to 24 steps of 25 ps.
// - Fine skew codes above 23 add no further delay.
// - Coarse skew is flip-flop based, 17 steps of half a VCO period.
// - Coarse skew codes above 17 add no further delay.
// - Slip count is low byte plus high nibble; step is count VCO periods.
// - Repeated slipping repeats every slip event by the twelve-bit count.
// - Two-bit source select: divider, analog delay, paired channel, VCO clock.
// - A divide ratio of 1 passes the undivided VCO clock.
// - Bits 7:6 override idle level in pulse generator mode; 00 normal.
// - Slip without repeat moves phase one VCO period per explicit request.
// - Repeat enable defaults 0 for reference, 1 for device clock channels.
// - Divider supports even 2 to 4094 and odd 1, 3, 5 at 50 percent.
`ifndef OCCFG_REGS_VH
`define OCCFG_REGS_VH

// Register byte offsets
`define OCCFG_ADDR_FINE_SKEW     8'hcb
`define OCCFG_ADDR_COARSE_SKEW   8'hcc
`define OCCFG_ADDR_SLIP_LOW      8'hcd
`define OCCFG_ADDR_SLIP_HIGH     8'hce
`define OCCFG_ADDR_SOURCE_SEL    8'hcf
`define OCCFG_ADDR_IDLE_OVR      8'hd0
`define OCCFG_ADDR_DIV_HIGH      8'he8

// Field positions
`define OCCFG_SKEW_MSB           4
`define OCCFG_NIBBLE_MSB         3
`define OCCFG_SRC_MSB            1
`define OCCFG_IDLE_MSB           7
`define OCCFG_IDLE_LSB           6

// Reset values
`define OCCFG_RST_BYTE           8'h00

// Field codes and limits
`define OCCFG_FINE_MAX           5'h17
`define OCCFG_COARSE_MAX         5'h11
`define OCCFG_SRC_DIVIDER        2'h0
`define OCCFG_SRC_ANALOG         2'h1
`define OCCFG_SRC_PAIR           2'h2
`define OCCFG_SRC_VCO            2'h3
`define OCCFG_IDLE_NORMAL        2'h0
`define OCCFG_IDLE_LOGIC0        2'h2

// Timing: one MCLK cycle models half a VCO period
`define OCCFG_HALF_PER_VCO       2'h2

`endif

// file: tb/occfg_channel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module occfg_channel_tb_top;
  logic        mclk, rst_b, we, re, slip_en, ms_we, ms_val, pg_mode, pg_idle;
  logic        ser, general_purpose_input, sync, pg_req, ana, pair, rvalid, clk_out, busy, ms_on;
  logic [7:0]  addr, wdata, div_lo, rdata, v;
  logic [4:0]  fine;
  logic [11:0] half;
  logic [31:0] seed;
  int          error_cnt, cmp_count, i, t0, t1, t2;
  logic [7:0]  ads [7] = '{8'hcb, 8'hcc, 8'hcd, 8'hce, 8'hcf, 8'hd0, 8'he8};
  logic [11:0] rt [5] = '{12'h001, 12'h003, 12'h005, 12'h00a, 12'h102};
  occfg_channel DUT (
    .MCLK(mclk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we),
    .REG_RE(re), .REG_RDATA(rdata), .REG_RVALID(rvalid), .DIV_RATIO_LOW(div_lo),
    .SLIP_ENABLE(slip_en), .MULTISLIP_WE(ms_we), .MULTISLIP_VALUE(ms_val),
    .PULSE_GEN_MODE(pg_mode), .PULSE_IDLE(pg_idle), .SERIAL_SLIP(ser),
    .GENERAL_PURPOSE_INPUT(general_purpose_input), .SYNC_EVENT(sync), .PULSE_GEN_REQ(pg_req),
    .ANALOG_DELAY_IN(ana), .PAIR_CHANNEL_IN(pair), .FINE_SKEW_STEPS(fine),
    .CLK_OUT(clk_out), .SLIP_BUSY(busy), .MULTISLIP_ON(ms_on));
  occfg_rx_model u_rx (.MCLK(mclk), .CLK_IN(clk_out), .half_q(half));
  // Clock and hang guard
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  initial
  begin
    #1800000;
    error_cnt++;
    summarize();
  end
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  // Reserved bits read back as zero
  function automatic logic [7:0] mask_of(input logic [7:0] a);
    case (a)
      8'hcd: return 8'hff;
      8'hce, 8'he8: return 8'h0f;
      8'hcf: return 8'h03;
      8'hd0: return 8'hc0;
      default: return 8'h1f;
    endcase
  endfunction
  function automatic logic [4:0] fine_exp(input logic [4:0] c);
    return (c > 5'h17) ? 5'h17 : c;
  endfunction
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge mclk);
    we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    addr = a;
    re = 1'b1;
    @(negedge mclk);
    re = 1'b0;
    chk(rvalid, 1'b1);
    chk(rdata, e);
  endtask
  task automatic ms_set(input logic b);
    @(negedge mclk);
    ms_val = b;
    ms_we = 1'b1;
    @(negedge mclk);
    ms_we = 1'b0;
    tick(2);
    chk(ms_on, b);
  endtask
  // Pulse one slip source, then count frozen cycles with a bound
  task automatic slip(input int s, input logic [12:0] exp);
    int k, n;
    @(negedge mclk);
    {pg_req, sync, general_purpose_input, ser} = 4'h1 << s;
    @(negedge mclk);
    {pg_req, sync, general_purpose_input, ser} = 4'h0;
    n = 0;
    for (k = 0; k < 1200; k++)
    begin
      @(negedge mclk);
      if (busy === 1'b1) n++;
      else if (n > 0 || k > 12) break;
    end
    if (k == 1200)
    begin
      error_cnt++;
      $display("ERROR %0t slip wait timeout", $time);
      summarize();
    end
    chk(n, exp);
  endtask
  // Restart the divider, then time the first output rise for one coarse code
  task automatic coarse_run(input logic [4:0] c, output int t);
    int k;
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    wr(8'hcc, {3'h0, c});
    t = 0;
    for (k = 0; k < 200 && clk_out !== 1'b1; k++)
    begin
      tick(1);
      t++;
    end
    if (k == 200)
    begin
      error_cnt++;
      $display("ERROR %0t coarse wait timeout", $time);
      summarize();
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    seed = 32'h9584;
    {rst_b, we, re, slip_en, ms_we, ms_val, pg_mode, pg_idle} = 8'h00;
    {ser, general_purpose_input, sync, pg_req, ana, pair} = 6'h00;
    {addr, wdata, div_lo} = 24'h000004;
    tick(3);
    rst_b = 1'b1;
    tick(2);
    chk(ms_on, 1'b1);
    for (i = 0; i < 7; i++)
    begin
      v = rnd();
      wr(ads[i], v);
      rd(ads[i], v & mask_of(ads[i]));
    end
    rd(8'hd1, 8'h00);
    for (i = 0; i < 32; i++)
    begin
      wr(8'hcb, i[7:0]);
      tick(2);
      chk(fine, fine_exp(i[4:0]));
    end
    // Period follows ratio whatever the coarse code
    wr(8'hcf, 8'h00);
    wr(8'hd0, 8'h00);
    for (i = 0; i < 5; i++)
    begin
      wr(8'he8, {4'h0, rt[i][11:8]});
      div_lo = rt[i][7:0];
      wr(8'hcc, rnd() & 8'h1f);
      tick(3 * rt[i] + 40);
      chk(half, rt[i]);
    end
    wr(8'hcc, 8'h00);
    wr(8'hcf, 8'h03);
    tick(6);
    chk(half, 12'h001);
    {pg_mode, pg_idle} = 2'h3;
    wr(8'hd0, 8'h80);
    tick(6);
    for (i = 0; i < 4; i++)
    begin
      tick(1);
      chk(clk_out, 1'b0);
    end
    wr(8'hd0, 8'h00);
    tick(6);
    chk(half, 12'h001);
    {pg_mode, pg_idle} = 2'h0;
    wr(8'hcf, 8'h02);
    for (i = 0; i < 4; i++)
    begin
      {pair, ana} = {i[0], ~i[0]};
      tick(8);
      chk(clk_out, i[0]);
    end
    wr(8'hcf, 8'h01);
    for (i = 0; i < 2; i++)
    begin
      ana = i[0];
      tick(8);
      chk(clk_out, i[0]);
    end
    wr(8'hcf, 8'h00);
    ms_set(1'b0);
    slip_en = 1'b1;
    for (i = 0; i < 4; i++) slip(i, (i < 2) ? 13'h2 : 13'h0);
    v = rnd();
    wr(8'hcd, v);
    wr(8'hce, 8'h01);
    ms_set(1'b1);
    for (i = 0; i < 4; i++) slip(i, {v, 1'b0} + 13'h200);
    wr(8'hce, 8'h00);
    wr(8'hcd, 8'h00);
    slip(0, 13'h0);
    wr(8'hcd, 8'h03);
    slip_en = 1'b0;
    slip(0, 13'h0);
    // Mid-run restart: first output rise moves one cycle per coarse step
    div_lo = 8'h28;
    coarse_run(5'h00, t0);
    chk(ms_on, 1'b1);
    coarse_run(5'h11, t1);
    chk(t1 - t0, 13'h011);
    coarse_run(5'h1f, t2);
    chk(t2, t1);
    summarize();
  end
endmodule
bind occfg_channel occfg_chk u_chk (
  .MCLK(MCLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_RE(REG_RE), .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID), .SLIP_ENABLE(SLIP_ENABLE), .SERIAL_SLIP(SERIAL_SLIP),
  .MULTISLIP_WE(MULTISLIP_WE), .MULTISLIP_VALUE(MULTISLIP_VALUE),
  .FINE_SKEW_STEPS(FINE_SKEW_STEPS), .CLK_OUT(CLK_OUT), .SLIP_BUSY(SLIP_BUSY),
  .MULTISLIP_ON(MULTISLIP_ON));
`default_nettype wire

// file: tb/occfg_chk.sv
`timescale 1ns/1ps
`default_nettype none
module occfg_chk (
  input wire logic       MCLK,            // Clock
  input wire logic       RST_B,           // Reset, low
  input wire logic [7:0] REG_ADDR,        // Address
  input wire logic       REG_RE,          // Read strobe
  input wire logic [7:0] REG_RDATA,       // Read data
  input wire logic       REG_RVALID,      // Read valid
  input wire logic       SLIP_ENABLE,     // Slip gate
  input wire logic       SERIAL_SLIP,     // Serial slip
  input wire logic       MULTISLIP_WE,    // Repeat load
  input wire logic       MULTISLIP_VALUE, // Repeat value
  input wire logic [4:0] FINE_SKEW_STEPS, // Fine steps
  input wire logic       CLK_OUT,         // Output clock
  input wire logic       SLIP_BUSY,       // Slip running
  input wire logic       MULTISLIP_ON     // Repeat state
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // Single slip: request, one quiet cycle, then two frozen cycles
  sequence s_one; SERIAL_SLIP && SLIP_ENABLE && !MULTISLIP_ON && !SLIP_BUSY; endsequence
  sequence s_two; SLIP_BUSY [*2] ##1 !SLIP_BUSY; endsequence
  property p_slip_one; s_one |-> ##2 s_two; endproperty
  a_slip_one: assert property (p_slip_one) else $error("single slip length");
  property p_rvalid; REG_RVALID == $past(REG_RE); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid timing");
  property p_rdata_idle; !REG_RVALID |-> REG_RDATA == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_fine_rsv; REG_RE && REG_ADDR == 8'hcb |=> REG_RDATA[7:5] == 3'h0; endproperty
  a_fine_rsv: assert property (p_fine_rsv) else $error("fine upper bits set");
  // Holes in the map read as zero
  property p_hole; REG_RE && !(REG_ADDR inside {[8'hcb:8'hd0], 8'he8}) |=> REG_RDATA == 8'h00;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  property p_fine_max; FINE_SKEW_STEPS <= 5'h17; endproperty
  a_fine_max: assert property (p_fine_max) else $error("fine steps above limit");
  property p_ms_load; MULTISLIP_WE |-> ##2 MULTISLIP_ON == $past(MULTISLIP_VALUE, 2); endproperty
  a_ms_load: assert property (p_ms_load) else $error("repeat enable load");
  // Reset is checked itself, so no disable here
  property p_rst; disable iff (1'b0) !RST_B ##1 !RST_B |-> !CLK_OUT && !SLIP_BUSY && !REG_RVALID;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared in reset");
endmodule
`default_nettype wire

// file: tb/occfg_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module occfg_rx_model (
  input  wire logic        MCLK,   // Bench clock
  input  wire logic        CLK_IN, // Channel output
  output var  logic [11:0] half_q  // Last level run
);
  logic [11:0] run_q;
  logic        last_q;
  // Receiver sees only level runs; jitter-free sampling at MCLK
  always @(posedge MCLK)
  begin
    last_q <= CLK_IN;
    if (CLK_IN != last_q)
    begin
      half_q <= run_q;
      run_q  <= 12'h001;
    end
    else
      run_q <= run_q + 12'h001;
  end
endmodule
`default_nettype wire
